// *** hw/opdec_map.vh ***
// Opcode field positions and encodings for the decimal-add, exchange and add decoder.
`ifndef OPDEC_MAP_VH
`define OPDEC_MAP_VH
// ==========================================================================
// Group codes in bits 15..12
`define GRP_ANDX      4'hC
`define GRP_ADD       4'hD
`define GRP_SHIFT     4'hE
// ==========================================================================
// Exchange mode field in bits 7..3
`define XMODE_DATA    5'h08
`define XMODE_ADDR    5'h09
`define XMODE_MIXED   5'h11
// ==========================================================================
// Operand sizes
`define SIZE_BYTE     2'h0
`define SIZE_WORD     2'h1
`define SIZE_LONG     2'h2
// ==========================================================================
// Shift and rotate kinds
`define SHK_ARITH     2'h0
`define SHK_LOGIC     2'h1
`define SHK_ROTX      2'h2
`define SHK_ROT       2'h3
// ==========================================================================
// Operation kind codes on op_kind
`define OPK_NONE      4'h0
`define OPK_DECADD    4'h1
`define OPK_SWAPD     4'h2
`define OPK_SWAPA     4'h3
`define OPK_SWAPM     4'h4
`define OPK_ADD       4'h5
`define OPK_ADDEXT    4'h6
`define OPK_SHIFT     4'h7
// ==========================================================================
// AHB register byte offsets
`define REG_INSN      8'h00
`define REG_RESULT    8'h04
`endif

// *** hw/size_decode.v ***
// Two-bit size field to size code, with a validity flag.
`timescale 1ns/1ps
module size_decode
(
  input  wire [1:0] size_field,
  output wire [1:0] size_code,
  output wire       size_ok
);
  // Code 11 is not a size; the caller treats the opcode as not decoded.
  assign size_code = size_field;
  assign size_ok   = (size_field != 2'h3);
endmodule // size_decode

// *** hw/opcode_decoder.v ***
// Decoder for the decimal-add, exchange, add and register shift opcodes.
`timescale 1ns/1ps
`include "opdec_map.vh"
// Summary of operation
// - Decimal add: C group, b8 set, b7..4 zero.
// - Decimal add b3: 0 register, 1 memory.
// - Register form: both fields name data registers.
// - Mode 01000 swaps two data registers.
// - Mode 01001 swaps two address registers.
// - Mode 10001 swaps data with address register.
// - Add mode picks size and destination.
// - Add-extended: D group, b8 set, b5..4 zero.
// - Add-extended b3: 0 register, 1 memory.
// - Memory form uses address registers, predecrement.
module opcode_decoder
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [3:0]  op_kind,
  output reg  [1:0]  op_size,
  output reg  [2:0]  dst_reg,
  output reg  [2:0]  src_reg,
  output reg         dst_is_addr,
  output reg         src_is_addr,
  output reg         predec_mode,
  output reg         memory_form,
  output reg         result_to_ea,
  output reg  [1:0]  shift_kind,
  output reg         shift_left,
  output reg         count_in_reg
);
  // ==========================================================================
  // Bus slave
  // The bus never stalls and hsize is ignored, since every register is one aligned word.
  // Only the low address byte is decoded, so the two registers repeat through the slot.
  reg  [15:0] insn_ff;
  reg         wr_pend_ff;
  reg  [7:0]  addr_ff;
  wire        take = hsel & hready & htrans[1];
  wire [15:0] nxt_insn = (wr_pend_ff && addr_ff == `REG_INSN) ? hwdata[15:0] : insn_ff;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      insn_ff    <= 16'h0000;
      wr_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end
    else
    begin
      insn_ff    <= nxt_insn;
      wr_pend_ff <= take & hwrite;
      if (take)
      begin
        addr_ff <= haddr[7:0];
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // ==========================================================================
  // Decode
  wire [3:0]  grp                  = insn_ff[15:12];
  wire [2:0]  rx                   = insn_ff[11:9];
  wire [2:0]  ry                   = insn_ff[2:0];
  wire [2:0]  operation_mode_field = insn_ff[8:6];
  wire [1:0]  szc;
  wire        szok;
  size_decode u_size
  (
    .size_field (insn_ff[7:6]),
    .size_code  (szc),
    .size_ok    (szok)
  );
  // ==========================================================================
  // Opcode matches
  // Swaps share the decimal-add group; only bits 7..3 tell them apart.
  wire        c_group_b8 = (grp == `GRP_ANDX) && insn_ff[8];
  wire        hit_decadd = c_group_b8 && (insn_ff[7:4] == 4'h0);
  wire        hit_swapd  = c_group_b8 && (insn_ff[7:3] == `XMODE_DATA);
  wire        hit_swapa  = c_group_b8 && (insn_ff[7:3] == `XMODE_ADDR);
  wire        hit_swapm  = c_group_b8 && (insn_ff[7:3] == `XMODE_MIXED);
  wire        hit_addext = (grp == `GRP_ADD) && insn_ff[8] && (insn_ff[5:4] == 2'h0) && szok;
  wire        hit_add    = (grp == `GRP_ADD) && (operation_mode_field[1:0] != 2'h3);
  wire        hit_shift  = (grp == `GRP_SHIFT) && szok;
  reg  [3:0]  nxt_op_kind;
  reg  [1:0]  nxt_op_size;
  reg         nxt_dst_is_addr;
  reg         nxt_src_is_addr;
  reg         nxt_predec_mode;
  reg         nxt_memory_form;
  reg         nxt_result_to_ea;
  always @*
  begin
    nxt_op_kind      = `OPK_NONE;
    nxt_op_size      = `SIZE_BYTE;
    nxt_dst_is_addr  = 1'b0;
    nxt_src_is_addr  = 1'b0;
    nxt_predec_mode  = 1'b0;
    nxt_memory_form  = 1'b0;
    nxt_result_to_ea = 1'b0;
    if (hit_decadd)
    begin
      nxt_op_kind     = `OPK_DECADD;
      nxt_memory_form = insn_ff[3];
      nxt_dst_is_addr = insn_ff[3];
      nxt_src_is_addr = insn_ff[3];
      nxt_predec_mode = insn_ff[3];
    end
    else if (hit_swapd)
    begin
      // Swaps move whole registers, so they report long size.
      nxt_op_kind = `OPK_SWAPD;
      nxt_op_size = `SIZE_LONG;
    end
    else if (hit_swapa)
    begin
      nxt_op_kind     = `OPK_SWAPA;
      nxt_op_size     = `SIZE_LONG;
      nxt_dst_is_addr = 1'b1;
      nxt_src_is_addr = 1'b1;
    end
    else if (hit_swapm)
    begin
      nxt_op_kind     = `OPK_SWAPM;
      nxt_op_size     = `SIZE_LONG;
      nxt_src_is_addr = 1'b1;
    end
    else if (hit_addext)
    begin
      // Checked before plain add, since these codes overlap add modes 100..110.
      nxt_op_kind     = `OPK_ADDEXT;
      nxt_op_size     = szc;
      nxt_memory_form = insn_ff[3];
      nxt_dst_is_addr = insn_ff[3];
      nxt_src_is_addr = insn_ff[3];
      nxt_predec_mode = insn_ff[3];
    end
    else if (hit_add)
    begin
      // Mode codes x11 belong to another instruction and decode to none here.
      nxt_op_kind      = `OPK_ADD;
      nxt_op_size      = operation_mode_field[1:0];
      nxt_result_to_ea = operation_mode_field[2];
    end
    else if (hit_shift)
    begin
      nxt_op_kind = `OPK_SHIFT;
      nxt_op_size = szc;
    end
  end
  // ==========================================================================
  // Decoded outputs
  // Registering the fields costs a cycle but gives the datapath a clean word.
  // Shift fields pass raw; they mean something only while op_kind says shift.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_kind      <= `OPK_NONE;
      op_size      <= `SIZE_BYTE;
      dst_reg      <= 3'h0;
      src_reg      <= 3'h0;
      dst_is_addr  <= 1'b0;
      src_is_addr  <= 1'b0;
      predec_mode  <= 1'b0;
      memory_form  <= 1'b0;
      result_to_ea <= 1'b0;
      shift_kind   <= `SHK_ARITH;
      shift_left   <= 1'b0;
      count_in_reg <= 1'b0;
    end
    else
    begin
      op_kind      <= nxt_op_kind;
      op_size      <= nxt_op_size;
      dst_reg      <= rx;
      src_reg      <= ry;
      dst_is_addr  <= nxt_dst_is_addr;
      src_is_addr  <= nxt_src_is_addr;
      predec_mode  <= nxt_predec_mode;
      memory_form  <= nxt_memory_form;
      result_to_ea <= nxt_result_to_ea;
      shift_kind   <= insn_ff[4:3];
      shift_left   <= insn_ff[8];
      count_in_reg <= insn_ff[5];
    end
  end
  // ==========================================================================
  // Read data
  wire [31:0] result_word = {15'h0000, result_to_ea, memory_form, predec_mode, src_is_addr,
                             dst_is_addr, src_reg, dst_reg, op_size, op_kind};
  reg  [31:0] rd;
  always @*
  begin
    case (addr_ff)
      `REG_INSN:
      begin
        rd = {16'h0000, insn_ff};
      end
      `REG_RESULT:
      begin
        rd = result_word;
      end
      default:
      begin
        rd = 32'h00000000;
      end
    endcase
  end
  assign hrdata = rd;
endmodule // opcode_decoder

// *** testbench/opcode_decoder_props.sv ***
// Concurrent checks on the opcode decoder ports.
`timescale 1ns/1ps
module opcode_decoder_props
(
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire [3:0]  op_kind,
  input wire [1:0]  op_size,
  input wire        dst_is_addr,
  input wire        src_is_addr,
  input wire        predec_mode,
  input wire        memory_form,
  input wire        result_to_ea
);
  // ==========
  // Write tracking
  // High in the data phase of a write to the instruction word.
  reg wr_ff;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_ff <= 1'b0;
    else if (hready) wr_ff <= hsel & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
  // ==========
  // Properties
  property p_dsz; op_kind == 4'h1 |-> op_size == 2'h0; endproperty
  a_dsz: assert property (p_dsz) else $error("Decimal add size wrong.");
  property p_dreg; op_kind == 4'h1 && !memory_form |-> !dst_is_addr && !src_is_addr; endproperty
  a_dreg: assert property (p_dreg) else $error("Register form flags wrong.");
  property p_mem;
    op_kind inside {4'h1, 4'h6} |-> {predec_mode, dst_is_addr, src_is_addr} == {3{memory_form}};
  endproperty
  a_mem: assert property (p_mem) else $error("Memory form flags wrong.");
  property p_swd; op_kind == 4'h2 |-> !dst_is_addr && !src_is_addr; endproperty
  a_swd: assert property (p_swd) else $error("Data swap flags wrong.");
  property p_swa; op_kind == 4'h3 |-> dst_is_addr && src_is_addr; endproperty
  a_swa: assert property (p_swa) else $error("Address swap flags wrong.");
  property p_swm; op_kind == 4'h4 |-> !dst_is_addr && src_is_addr; endproperty
  a_swm: assert property (p_swm) else $error("Mixed swap flags wrong.");
  property p_ea; result_to_ea |-> op_kind == 4'h5 && op_size != 2'h3; endproperty
  a_ea: assert property (p_ea) else $error("Result to address wrong.");
  property p_shf;
    wr_ff && hwdata[15:12] == 4'hE && hwdata[7:6] != 2'h3 |=> ##1
      op_kind == 4'h7 && op_size == $past(hwdata[7:6], 2);
  endproperty
  a_shf: assert property (p_shf) else $error("Shift decode wrong.");
  c_mem: cover property (op_kind == 4'h6 && memory_form);
  c_swm: cover property (op_kind == 4'h4);
  c_shf: cover property (op_kind == 4'h7);
endmodule // opcode_decoder_props
bind opcode_decoder opcode_decoder_props chk
(
  .hclk         (hclk),
  .hresetn      (hresetn),
  .hsel         (hsel),
  .haddr        (haddr),
  .htrans       (htrans),
  .hwrite       (hwrite),
  .hready       (hready),
  .hwdata       (hwdata),
  .op_kind      (op_kind),
  .op_size      (op_size),
  .dst_is_addr  (dst_is_addr),
  .src_is_addr  (src_is_addr),
  .predec_mode  (predec_mode),
  .memory_form  (memory_form),
  .result_to_ea (result_to_ea)
);

// *** testbench/insn_fetch.sv ***
// Fetch-side model: a table of instruction words on field boundaries.
`timescale 1ns/1ps
module insn_fetch
(
  input  wire [3:0]  pc,
  output wire [15:0] insn
);
  localparam [255:0] ROM = {16'hC305, 16'hC30D, 16'hC341, 16'hC349, 16'hC38A, 16'hC318,
    16'hD000, 16'hD0C0, 16'hD103, 16'hD10B, 16'hD180, 16'hD1C0, 16'hD150, 16'hE118,
    16'hE0D8, 16'hE010};
  assign insn = ROM[pc*16 +: 16];
endmodule // insn_fetch

// *** testbench/bcd_exchange_add_opcode_decoder_tb.sv ***
// Self-checking bench for the opcode decoder over its register bus.
`timescale 1ns/1ps
`include "opdec_map.vh"
module bcd_exchange_add_opcode_decoder_tb;
  reg         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  reg  [31:0] haddr = 0, hwdata = 0, lfsr = 32'hA09828E8, rd;
  reg  [2:0]  hsize = 3'h2;
  reg  [1:0]  htrans = 0;
  reg  [3:0]  pc = 0;
  wire [31:0] hrdata;
  wire [15:0] corner;
  wire [3:0]  kind;
  wire [1:0]  sk;
  wire        hreadyout, hresp, sl, cr;
  integer     miscompares = 0, n_compared = 0, i;
  always #2 hclk = ~hclk;
  insn_fetch fetch (.pc(pc), .insn(corner));
  opcode_decoder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .op_kind(kind), .op_size(),
    .dst_reg(), .src_reg(), .dst_is_addr(), .src_is_addr(), .predec_mode(), .memory_form(),
    .result_to_ea(), .shift_kind(sk), .shift_left(sl), .count_in_reg(cr));
  // ==========
  // Expectations
  function [16:0] model(input [15:0] w);
    reg [3:0] k, f;
    reg [1:0] z;
    begin
      k = 0; z = w[7:6]; f = 0;
      case (w[15:12])
        4'hC: if (w[8]) case (w[7:3])
          5'h00, 5'h01: begin k = 1; z = 0; f = {4{w[3]}}; end
          5'h08: begin k = 2; z = 2; end
          5'h09: begin k = 3; z = 2; f = 4'h3; end
          5'h11: begin k = 4; z = 2; f = 4'h2; end
        endcase
        4'hD: if (w[8] && w[5:4] == 2'h0) begin k = z != 3 ? 6 : 0; f = {4{w[3]}}; end
          else begin k = z != 3 ? 5 : 0; f = 0; end
        4'hE: k = z != 3 ? 7 : 0;
      endcase
      model = {k == 5 && w[8], f, w[2:0], w[11:9], z, k};
    end
  endfunction
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [16:0] msk(input [3:0] k);
    msk = k == 0 ? 17'hF : k == 7 ? 17'hFFF : k == 5 ? 17'h10FFF : 17'h1FFFF;
  endfunction
  task check(input [31:0] seen, input [31:0] want);
    begin
      n_compared = n_compared + 1;
      if (seen !== want) begin
        miscompares = miscompares + 1;
        $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, want);
      end
    end
  endtask
  // ==========
  // Bus cycles
  // One single transfer; hangs are cut short by the watchdog.
  // It starts on a rising edge so that every request changes right after one.
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hsel <= 0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  task run(input [15:0] w);
    reg [16:0] e;
    begin
      e = model(w);
      bus(1, `REG_INSN, {lfsr[31:16], w});
      @(posedge hclk); #1;
      check(kind, e[3:0]);
      if (e[3:0] == `OPK_SHIFT) check({sk, sl, cr}, {w[4:3], w[8], w[5]});
      bus(0, `REG_RESULT, 0);
      check(rd & msk(e[3:0]), e & msk(e[3:0]));
      bus(0, `REG_INSN, 0);
      check(rd[15:0], w);
    end
  endtask
  task give_verdict;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #100000;
    miscompares = miscompares + 1;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk); #1;
    check({hreadyout, hresp, kind}, 6'h20);
    for (i = 0; i < 16; i = i + 1) begin pc = i; #1 run(corner); end
    $display("Corner words done");
    for (i = 0; i < 200; i = i + 1) begin
      lfsr = lfsr_next(lfsr);
      run({lfsr[20] ? 4'hC + lfsr[19:18] % 2'd3 : lfsr[15:12], lfsr[11:0]});
    end
    $display("Random words done");
    bus(0, 32'h8, 0);
    check(rd, 0);
    $display("Unmapped read done");
    give_verdict;
  end
endmodule // bcd_exchange_add_opcode_decoder_tb
